// file: dpq_bp_select.sv
// block versus median-adaptive decision shared by both ends
`timescale 1ns/1ps
`default_nettype none
`include "dpq_map.svh"
module dpq_bp_select
  import dpq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic advance_i,
  input wire logic line_start_i,
  input wire logic [`DPQ_HW-1:0] group_horizontal_position_i,
  input wire logic partial_i,
  input wire logic bp_enable_i,
  input wire dpq_mode_t mode_i,
  input wire logic [3:0] bit_depth_i,
  input wire dpq_win_t window_i,
  output logic use_bp_o,
  output logic [3:0] block_vector_o
);
  logic [2:0] block_predict_run_count_reg;
  logic [2:0] block_predict_run_count_next;
  logic [2:0] edge_distance_count_reg;
  logic [2:0] edge_distance_count_next;
  logic [10:0] vector_search_cost [`DPQ_NCAND];
  logic [3:0] best_k;

  function automatic logic [3:0] search_displacements(input int k);
    search_displacements = (k == 0) ? 4'h1 : 4'(k + 2);
  endfunction : search_displacements

  function automatic logic [11:0] absd(input dpq_smp_t a, input dpq_smp_t b);
    absd = (a > b) ? a - b : b - a;
  endfunction : absd

  // search cost per displacement
  always_comb
  begin
    logic [10:0] part;
    logic [11:0] saturated_abs_difference;
    int idx;
    part = '0;
    saturated_abs_difference = '0;
    idx = 0;
    for (int k = 0; k < `DPQ_NCAND; k++)
    begin
      vector_search_cost[k] = '0;
      for (int p = 0; p < 3; p++)
      begin
        part = '0;
        for (int j = 0; j < 3; j++)
        begin
          idx = `DPQ_REF0 + 3 * p + j;
          for (int c = 0; c < 3; c++)
            if (c == 0 || mode_i != DPQ_MODE_420)
            begin
              saturated_abs_difference = absd(window_i[idx][c], window_i[idx - int'(search_displacements(k))][c])
                                         >> (bit_depth_i - `DPQ_ABS_SHIFT);
              if (saturated_abs_difference > `DPQ_ABS_SAT)
                saturated_abs_difference = `DPQ_ABS_SAT;
              part = part + saturated_abs_difference[10:0];
            end
        end
        if (part > `DPQ_PART_SAT)
          part = `DPQ_PART_SAT;
        vector_search_cost[k] = vector_search_cost[k] + part;
      end
      if (vector_search_cost[k] > `DPQ_PART_SAT)
        vector_search_cost[k] = `DPQ_PART_SAT;
    end
  end

  // lowest cost, earlier candidate wins ties
  always_comb
  begin
    logic [10:0] best;
    best = vector_search_cost[0];
    best_k = 4'h0;
    for (int k = 1; k < `DPQ_NCAND; k++)
      if (vector_search_cost[k] < best)
      begin
        best = vector_search_cost[k];
        best_k = 4'(k);
      end
  end

  // edge tracking over the previous-line pixels of the group
  always_comb
  begin
    logic [11:0] thr;
    logic hit;
    thr = `DPQ_EDGE_BASE << (bit_depth_i - `DPQ_EDGE_SHIFT);
    hit = 1'b0;
    edge_distance_count_next = line_start_i ? `DPQ_CNT_SAT : edge_distance_count_reg;
    for (int j = 0; j < 3; j++)
    begin
      hit = 1'b0;
      for (int c = 0; c < 3; c++)
        if (absd(window_i[`DPQ_EDGE0 + j][c], window_i[`DPQ_EDGE0 + j - 1][c]) > thr)
          hit = 1'b1;
      if (hit)
        edge_distance_count_next = 3'h0;
      else if (edge_distance_count_next != `DPQ_CNT_SAT)
        edge_distance_count_next = edge_distance_count_next + 3'h1;
    end
  end

  always_comb
  begin
    if (!bp_enable_i || best_k == 4'h0)
      block_predict_run_count_next = 3'h0;
    else if (group_horizontal_position_i >= `DPQ_GROUP_HORIZONTAL_POSITION_MIN && block_predict_run_count_reg != `DPQ_CNT_SAT)
      block_predict_run_count_next = block_predict_run_count_reg + 3'h1;
    else
      block_predict_run_count_next = block_predict_run_count_reg;
  end

  assign use_bp_o = bp_enable_i && best_k != 4'h0 && block_predict_run_count_next >= `DPQ_RUN_MIN
                    && edge_distance_count_next < `DPQ_EDGE_MAX && !partial_i;
  assign block_vector_o = search_displacements(int'(best_k));

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      block_predict_run_count_reg <= 3'h0;
    else if (advance_i)
      block_predict_run_count_reg <= block_predict_run_count_next;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      edge_distance_count_reg <= `DPQ_CNT_SAT;
    else if (advance_i)
      edge_distance_count_reg <= edge_distance_count_next;
  end
endmodule : dpq_bp_select
`default_nettype wire

// file: dpq_dec.sv
// decoder end: same decision, inverse quantization and reconstruction
`timescale 1ns/1ps
`default_nettype none
`include "dpq_map.svh"
module dpq_dec
  import dpq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  dpq_link_if.dec link,
  input wire logic window_valid_i,
  output logic window_ready_o,
  input wire dpq_win_t window_i,
  input wire logic bp_enable_i,
  input wire dpq_mode_t mode_i,
  input wire logic [3:0] bit_depth_i,
  output dpq_grp_t recon_o,
  output logic recon_valid_o
);
  dpq_hist_t hist_reg;
  dpq_grp_t rec_next;
  logic take;
  logic use_bp;
  logic [3:0] block_vector;

  assign link.ready = window_valid_i;
  assign window_ready_o = link.valid;
  assign take = link.valid && window_valid_i;

  dpq_bp_select u_select (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .advance_i(take),
    .line_start_i(link.line_start),
    .group_horizontal_position_i(link.group_horizontal_position),
    .partial_i(link.partial),
    .bp_enable_i(bp_enable_i),
    .mode_i(mode_i),
    .bit_depth_i(bit_depth_i),
    .window_i(window_i),
    .use_bp_o(use_bp),
    .block_vector_o(block_vector)
  );

  always_comb
  begin
    dpq_smp_t p;
    logic [3:0] ql;
    p = '0;
    ql = '0;
    rec_next = '0;
    for (int c = 0; c < 3; c++)
    begin
      ql = (c == 0) ? link.ql_luma : link.ql_chroma;
      for (int j = 0; j < 3; j++)
      begin
        if (link.mpp[c])
          p = dpq_mpp_pred(link.slice_start ? '0 : hist_reg[0][c], bit_depth_i, ql);
        else
          p = dpq_bpm_pred(hist_reg, dpq_bp_comp(use_bp, mode_i, c), block_vector, j, c,
                           link.line_start, bit_depth_i);
        rec_next[j][c] = dpq_recon(p, link.res[j][c], ql, bit_depth_i);
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hist_reg <= '0;
    else if (take)
    begin
      hist_reg[0] <= rec_next[2];
      hist_reg[1] <= rec_next[1];
      hist_reg[2] <= rec_next[0];
      for (int k = 3; k < `DPQ_HIST; k++)
        hist_reg[k] <= hist_reg[k - 3];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      recon_valid_o <= 1'b0;
      recon_o <= '0;
    end
    else
    begin
      recon_valid_o <= take;
      if (take)
        recon_o <= rec_next;
    end
  end
endmodule : dpq_dec
`default_nettype wire

// file: dpq_enc.sv
// encoder end: prediction select, quantization and reconstruction
`timescale 1ns/1ps
`default_nettype none
`include "dpq_map.svh"
module dpq_enc
  import dpq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire dpq_grp_t pix_i,
  input wire dpq_win_t window_i,
  input wire logic slice_start_i,
  input wire logic line_start_i,
  input wire logic partial_i,
  input wire logic [3:0] quant_luma_i,
  input wire logic [3:0] quant_chroma_i,
  input wire logic forced_midpoint_flag_i,
  input wire logic bp_enable_i,
  input wire dpq_mode_t mode_i,
  input wire logic [3:0] bit_depth_i,
  output dpq_grp_t recon_o,
  output logic recon_valid_o,
  output logic [2:0][4:0] unit_size_o,
  output logic [2:0] unit_mpp_o,
  dpq_link_if.enc link
);
  dpq_hist_t hist_reg;
  logic [`DPQ_HW-1:0] group_horizontal_position_reg;
  logic [`DPQ_HW-1:0] group_horizontal_position_cur;
  logic take;
  logic use_bp;
  logic [3:0] block_vector;
  dpq_rgrp_t res_next;
  dpq_grp_t rec_next;
  logic [2:0] mpp_next;
  logic [2:0][4:0] size_next;

  assign pix_ready_o = !link.valid || link.ready;
  assign take = pix_valid_i && pix_ready_o;
  assign group_horizontal_position_cur = line_start_i ? '0 : group_horizontal_position_reg;

  dpq_bp_select u_select (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .advance_i(take),
    .line_start_i(line_start_i),
    .group_horizontal_position_i(group_horizontal_position_cur),
    .partial_i(partial_i),
    .bp_enable_i(bp_enable_i),
    .mode_i(mode_i),
    .bit_depth_i(bit_depth_i),
    .window_i(window_i),
    .use_bp_o(use_bp),
    .block_vector_o(block_vector)
  );

  // per unit: block/median-adaptive trial, then midpoint fallback
  always_comb
  begin
    dpq_smp_t pb [3];
    dpq_res_t qb [3];
    dpq_smp_t pm;
    dpq_res_t qm;
    logic [3:0] ql;
    logic [4:0] lim;
    logic [4:0] mx;
    pb = '{default: '0};
    qb = '{default: '0};
    pm = '0;
    qm = '0;
    ql = '0;
    lim = '0;
    mx = '0;
    res_next = '0;
    rec_next = '0;
    mpp_next = '0;
    size_next = '0;
    for (int c = 0; c < 3; c++)
    begin
      ql = (c == 0) ? quant_luma_i : quant_chroma_i;
      lim = 5'(bit_depth_i) - 5'(ql);
      mx = 5'h00;
      for (int j = 0; j < 3; j++)
      begin
        pb[j] = dpq_bpm_pred(hist_reg, dpq_bp_comp(use_bp, mode_i, c), block_vector, j, c,
                             line_start_i, bit_depth_i);
        qb[j] = dpq_quant(dpq_diff(pix_i[j][c], pb[j]), ql);
        if (dpq_size(qb[j]) > mx)
          mx = dpq_size(qb[j]);
      end
      mpp_next[c] = forced_midpoint_flag_i || mx >= lim;
      size_next[c] = mpp_next[c] ? lim : mx;
      pm = dpq_mpp_pred(slice_start_i ? '0 : hist_reg[0][c], bit_depth_i, ql);
      for (int j = 0; j < 3; j++)
      begin
        qm = dpq_clip(dpq_quant(dpq_diff(pix_i[j][c], pm), ql), lim);
        if (mpp_next[c])
        begin
          res_next[j][c] = qm;
          rec_next[j][c] = dpq_recon(pm, qm, ql, bit_depth_i);
        end
        else
        begin
          res_next[j][c] = qb[j];
          rec_next[j][c] = dpq_recon(pb[j], qb[j], ql, bit_depth_i);
        end
      end
    end
  end

  // reconstructed history, newest pixel at index 0
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hist_reg <= '0;
    else if (take)
    begin
      hist_reg[0] <= rec_next[2];
      hist_reg[1] <= rec_next[1];
      hist_reg[2] <= rec_next[0];
      for (int k = 3; k < `DPQ_HIST; k++)
        hist_reg[k] <= hist_reg[k - 3];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      group_horizontal_position_reg <= '0;
    else if (take)
      group_horizontal_position_reg <= group_horizontal_position_cur + `DPQ_GROUP;
  end

  // link output stage, held until the decoder takes it
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      link.valid <= 1'b0;
    else if (take)
      link.valid <= 1'b1;
    else if (link.ready)
      link.valid <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link.res <= '0;
      link.mpp <= '0;
      link.ql_luma <= '0;
      link.ql_chroma <= '0;
      link.group_horizontal_position <= '0;
      link.slice_start <= 1'b0;
      link.line_start <= 1'b0;
      link.partial <= 1'b0;
    end
    else if (take)
    begin
      link.res <= res_next;
      link.mpp <= mpp_next;
      link.ql_luma <= quant_luma_i;
      link.ql_chroma <= quant_chroma_i;
      link.group_horizontal_position <= group_horizontal_position_cur;
      link.slice_start <= slice_start_i;
      link.line_start <= line_start_i;
      link.partial <= partial_i;
    end
  end

  // user-side results
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      recon_valid_o <= 1'b0;
    else
      recon_valid_o <= take;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      recon_o <= '0;
      unit_size_o <= '0;
      unit_mpp_o <= '0;
    end
    else if (take)
    begin
      recon_o <= rec_next;
      unit_size_o <= size_next;
      unit_mpp_o <= mpp_next;
    end
  end
endmodule : dpq_enc
`default_nettype wire

// file: dpq_link_chk.sv
// concurrent checks on the group link between the two ends
`timescale 1ns/1ps
`default_nettype none
`include "dpq_map.svh"
module dpq_link_chk
  import dpq_pkg::*;
#(
  parameter int BD = 8
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic valid,
  input wire logic ready,
  input wire dpq_rgrp_t res,
  input wire logic [2:0] mpp,
  input wire logic [3:0] ql_luma,
  input wire logic [3:0] ql_chroma,
  input wire logic [`DPQ_HW-1:0] group_horizontal_position,
  input wire logic slice_start,
  input wire logic line_start,
  input wire logic partial
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic [`DPQ_HW-1:0] last_group_horizontal_position_reg;
  logic seen_reg;

  // position of the last group handed over
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_group_horizontal_position_reg <= '0;
      seen_reg <= 1'b0;
    end
    else if (valid && ready)
    begin
      last_group_horizontal_position_reg <= group_horizontal_position;
      seen_reg <= 1'b1;
    end
  end

  function automatic logic fits(input dpq_res_t r, input logic [3:0] ql);
    int lim;
    lim = 1 << (BD - int'(ql) - 1);
    fits = (int'(r) >= -lim) && (int'(r) < lim);
  endfunction : fits

  sequence stall_s;
    valid && !ready;
  endsequence
  sequence take_s;
    valid && ready;
  endsequence

  link_hold_a: assert property (stall_s |=> valid && $stable(res) && $stable(mpp) && $stable(group_horizontal_position)
    && $stable(ql_luma) && $stable(ql_chroma)) else $error("link fields moved while stalled");
  group_grid_a: assert property (valid |-> group_horizontal_position % 3 == 0) else $error("group position off grid");
  line_zero_a: assert property (valid && line_start |-> group_horizontal_position == '0) else $error("line start not at zero");
  slice_line_a: assert property (valid && slice_start |-> line_start) else $error("slice start mid line");
  group_step_a: assert property (valid && !($past(valid) && !$past(ready)) && !line_start && seen_reg
    |-> group_horizontal_position == last_group_horizontal_position_reg + `DPQ_GROUP) else $error("group position did not step by three");
  luma_clip_a: assert property (valid && mpp[0] |-> fits(res[0][0], ql_luma) && fits(res[1][0], ql_luma)
    && fits(res[2][0], ql_luma)) else $error("luma midpoint residual too wide");
  chroma_clip_a: assert property (valid && (mpp[1] || mpp[2]) |->
    (!mpp[1] || (fits(res[0][1], ql_chroma) && fits(res[1][1], ql_chroma) && fits(res[2][1], ql_chroma)))
    && (!mpp[2] || (fits(res[0][2], ql_chroma) && fits(res[1][2], ql_chroma) && fits(res[2][2], ql_chroma))))
    else $error("chroma midpoint residual too wide");
  quant_range_a: assert property (valid |-> ql_luma < BD && ql_chroma < BD) else $error("quant level out of range");
  stall_take_c: cover property (stall_s ##1 take_s);
endmodule : dpq_link_chk
`default_nettype wire

// file: dpq_link_if.sv
// group link between encoder and decoder ends
`timescale 1ns/1ps
`default_nettype none
`include "dpq_map.svh"
interface dpq_link_if
  import dpq_pkg::*;
();
  logic valid;
  logic ready;
  dpq_rgrp_t res;
  logic [2:0] mpp;
  logic [3:0] ql_luma;
  logic [3:0] ql_chroma;
  logic [`DPQ_HW-1:0] group_horizontal_position;
  logic slice_start;
  logic line_start;
  logic partial;
  modport enc (output valid, res, mpp, ql_luma, ql_chroma, group_horizontal_position, slice_start, line_start, partial,
               input ready);
  modport dec (input valid, res, mpp, ql_luma, ql_chroma, group_horizontal_position, slice_start, line_start, partial,
               output ready);
endinterface : dpq_link_if
`default_nettype wire

// file: dpq_map.svh
// constants for the prediction select and quantizer ends
// Overview of operation
// - midpoint predictor: half range plus low recon bits
// - first slice group uses zero previous recon
// - both ends share one prediction decision procedure
// - no block prediction for chroma in 4:2:0
// - block prediction disabled means median-adaptive, no search
// - decision per three-pixel group, previous line only
// - nine reference pixels versus nine displacements
// - abs difference shifted by depth-7, saturated 0x3F
// - component mix of partial sums follows mode
// - partial sums and cost saturate at 511
// - lowest cost wins, ties to smallest magnitude
// - winner -1 clears run count, else counts from group position 9
// - block needs run>=3, edge<3, full group
// - edge threshold 32 shifted by depth-8
// - large residual size in unit selects midpoint
// - midpoint residual size is depth minus quant_level
// - rate control can force midpoint prediction
// - residual is input sample minus prediction
// - rounded magnitude shift by quant_level, sign restored
// - separate luma and chroma quant_level
// - midpoint residual clipped to its size
// - encoder reconstructs exactly like the decoder
`ifndef DPQ_MAP_SVH
`define DPQ_MAP_SVH
`define DPQ_SW 12
`define DPQ_RW 14
`define DPQ_HW 12
`define DPQ_WIN 19
`define DPQ_REF0 10
`define DPQ_EDGE0 16
`define DPQ_HIST 10
`define DPQ_NCAND 9
`define DPQ_ABS_SHIFT 4'h7
`define DPQ_ABS_SAT 12'h03F
`define DPQ_PART_SAT 11'h1FF
`define DPQ_RUN_MIN 3'h3
`define DPQ_EDGE_MAX 3'h3
`define DPQ_CNT_SAT 3'h7
`define DPQ_GROUP_HORIZONTAL_POSITION_MIN 12'h009
`define DPQ_GROUP 12'h003
`define DPQ_EDGE_BASE 12'h020
`define DPQ_EDGE_SHIFT 4'h8
`endif

// file: dpq_pkg.sv
// types and shared arithmetic for both ends
`include "dpq_map.svh"
package dpq_pkg;
  typedef logic [`DPQ_SW-1:0] dpq_smp_t;
  typedef dpq_smp_t [2:0] dpq_pix_t;
  typedef dpq_pix_t [2:0] dpq_grp_t;
  typedef dpq_pix_t [`DPQ_WIN-1:0] dpq_win_t;
  typedef dpq_pix_t [`DPQ_HIST-1:0] dpq_hist_t;
  typedef logic signed [`DPQ_RW-1:0] dpq_res_t;
  typedef dpq_res_t [2:0] dpq_rpix_t;
  typedef dpq_rpix_t [2:0] dpq_rgrp_t;
  typedef enum logic [1:0] {DPQ_MODE_444, DPQ_MODE_422, DPQ_MODE_420} dpq_mode_t;

  function automatic dpq_smp_t dpq_mid(input logic [3:0] bd);
    dpq_mid = dpq_smp_t'(12'h001 << (bd - 4'h1));
  endfunction : dpq_mid

  function automatic dpq_smp_t dpq_mpp_pred(input dpq_smp_t prev, input logic [3:0] bd, input logic [3:0] ql);
    dpq_mpp_pred = dpq_mid(bd) + (prev & dpq_smp_t'((13'h0001 << ql) - 13'h0001));
  endfunction : dpq_mpp_pred

  function automatic logic dpq_bp_comp(input logic bp, input dpq_mode_t mode, input int c);
    dpq_bp_comp = bp && !(mode == DPQ_MODE_420 && c != 0);
  endfunction : dpq_bp_comp

  function automatic dpq_smp_t dpq_bpm_pred(input dpq_hist_t h, input logic bp, input logic [3:0] mag,
                                            input int j, input int c, input logic ls, input logic [3:0] bd);
    if (bp)
      dpq_bpm_pred = h[mag - 4'(j) - 4'h1][c];
    else if (ls)
      dpq_bpm_pred = dpq_mid(bd);
    else
      dpq_bpm_pred = h[0][c];
  endfunction : dpq_bpm_pred

  function automatic dpq_res_t dpq_diff(input dpq_smp_t x, input dpq_smp_t p);
    dpq_diff = $signed({2'h0, x}) - $signed({2'h0, p});
  endfunction : dpq_diff

  function automatic dpq_res_t dpq_quant(input dpq_res_t e, input logic [3:0] ql);
    dpq_res_t rnd;
    rnd = (ql == 4'h0) ? '0 : dpq_res_t'((14'h0001 << (ql - 4'h1)) - 14'h0001);
    if (e < 0)
      dpq_quant = -((rnd - e) >>> ql);
    else
      dpq_quant = (e + rnd) >>> ql;
  endfunction : dpq_quant

  function automatic logic [4:0] dpq_size(input dpq_res_t q);
    logic [`DPQ_RW-1:0] m;
    m = q[`DPQ_RW-1] ? ~q : q;
    dpq_size = (q == '0) ? 5'h00 : 5'h01;
    for (int i = 0; i < `DPQ_RW; i++)
      if (m[i])
        dpq_size = 5'(i + 2);
  endfunction : dpq_size

  function automatic dpq_res_t dpq_clip(input dpq_res_t q, input logic [4:0] s);
    dpq_res_t hi;
    hi = dpq_res_t'((14'h0001 << (s - 5'h01)) - 14'h0001);
    if (q > hi)
      dpq_clip = hi;
    else if (q < -hi - 1)
      dpq_clip = -hi - 1;
    else
      dpq_clip = q;
  endfunction : dpq_clip

  function automatic dpq_smp_t dpq_recon(input dpq_smp_t p, input dpq_res_t q, input logic [3:0] ql,
                                         input logic [3:0] bd);
    logic signed [`DPQ_RW+1:0] v;
    dpq_smp_t mx;
    mx = dpq_smp_t'((13'h0001 << bd) - 13'h0001);
    v = $signed({4'h0, p}) + ($signed({{2{q[`DPQ_RW-1]}}, q}) <<< ql);
    if (v < 0)
      dpq_recon = '0;
    else if (v > $signed({4'h0, mx}))
      dpq_recon = mx;
    else
      dpq_recon = v[`DPQ_SW-1:0];
  endfunction : dpq_recon
endpackage : dpq_pkg

// file: dsc_predictor_select_quantizer_tb.sv
// testbench joining encoder and decoder ends over the group link
`timescale 1ns/1ps
`default_nettype none
module dsc_predictor_select_quantizer_tb
  import dpq_pkg::*;
();
  logic sys_clk_i = 1'b0;
  logic rst_i, pix_valid, slice_s, line_s, part, forced, bp_en, win_vld, pix_rdy, e_vld, d_vld, w_rdy;
  logic [3:0] ql_l, ql_c;
  logic [11:0] hp;
  dpq_mode_t mode;
  dpq_grp_t pix, e_rec, d_rec;
  dpq_win_t win_e, win_d;
  logic [2:0][4:0] u_sz;
  logic [2:0] u_mpp;
  int pat_lo, pat_hi, err_total, n_tests;

  always #12.5 sys_clk_i = ~sys_clk_i;

  function automatic dpq_smp_t pv(input int p, input int lo, input int hi);
    pv = (((p < 0) ? 0 : p) % 4 >= 2) ? dpq_smp_t'(hi) : dpq_smp_t'(lo);
  endfunction : pv

  function automatic dpq_win_t win_f(input logic [11:0] h, input int lo, input int hi);
    for (int i = 0; i < 19; i++)
      for (int c = 0; c < 3; c++)
        win_f[i][c] = pv(int'(h) - 16 + i, lo, hi);
  endfunction : win_f

  dpq_link_if dpq_link_if_i ();

  assign win_e = win_f(hp, pat_lo, pat_hi);
  assign win_d = win_f(dpq_link_if_i.group_horizontal_position, pat_lo, pat_hi);
  dpq_enc dpq_enc_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pix_valid_i(pix_valid), .pix_ready_o(pix_rdy),
    .pix_i(pix), .window_i(win_e), .slice_start_i(slice_s), .line_start_i(line_s), .partial_i(part),
    .quant_luma_i(ql_l), .quant_chroma_i(ql_c), .forced_midpoint_flag_i(forced), .bp_enable_i(bp_en),
    .mode_i(mode), .bit_depth_i(4'h8), .recon_o(e_rec), .recon_valid_o(e_vld), .unit_size_o(u_sz),
    .unit_mpp_o(u_mpp), .link(dpq_link_if_i.enc));
  dpq_dec dpq_dec_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(dpq_link_if_i.dec), .window_valid_i(win_vld),
    .window_ready_o(w_rdy), .window_i(win_d), .bp_enable_i(bp_en), .mode_i(mode), .bit_depth_i(4'h8),
    .recon_o(d_rec), .recon_valid_o(d_vld));
  dpq_link_chk dpq_link_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .valid(dpq_link_if_i.valid),
    .ready(dpq_link_if_i.ready), .res(dpq_link_if_i.res), .mpp(dpq_link_if_i.mpp),
    .ql_luma(dpq_link_if_i.ql_luma), .ql_chroma(dpq_link_if_i.ql_chroma), .group_horizontal_position(dpq_link_if_i.group_horizontal_position),
    .slice_start(dpq_link_if_i.slice_start), .line_start(dpq_link_if_i.line_start),
    .partial(dpq_link_if_i.partial));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic int qz(input int e, input int ql);
    int r;
    r = (ql > 0) ? (1 << (ql - 1)) - 1 : 0;
    qz = (e < 0) ? -((r - e) >>> ql) : (e + r) >>> ql;
  endfunction : qz

  function automatic int sz(input int q);
    int m;
    m = (q < 0) ? ~q : q;
    sz = (q != 0) ? 1 : 0;
    for (int i = 0; i < 14; i++)
      if (m[i])
        sz = i + 2;
  endfunction : sz

  function automatic int rc(input int p, input int q, input int ql);
    int v;
    v = p + q * (1 << ql);
    rc = (v < 0) ? 0 : (v > 255) ? 255 : v;
  endfunction : rc

  // one group in, both reconstructions judged; st stalls the link for a while
  task automatic send(input dpq_grp_t g, input dpq_grp_t ex, input logic ss, input logic [11:0] h,
                      input logic pt, input logic st);
    int k;
    @(negedge sys_clk_i);
    pix = g;
    slice_s = ss;
    line_s = (h == 12'h000);
    part = pt;
    hp = h;
    pix_valid = 1'b1;
    win_vld = !st;
    check(pix_rdy, 1'b1);
    @(negedge sys_clk_i);
    pix_valid = 1'b0;
    check(e_vld, 1'b1);
    check(e_rec, ex);
    if (st)
    begin
      check(pix_rdy, 1'b0);
      check(w_rdy, 1'b1);
      repeat (3) @(negedge sys_clk_i);
      win_vld = 1'b1;
    end
    k = 0;
    while (d_vld !== 1'b1 && k < 10)
    begin
      @(negedge sys_clk_i);
      k++;
    end
    check(d_vld, 1'b1);
    check(d_rec, ex);
  endtask : send

  // slice-start group with mixed unit choices, then a forced midpoint group
  task automatic t_pred();
    int xv[2][3][3];
    int prv[3];
    int ql, pr, q, mx, lim;
    dpq_grp_t g, ex;
    logic [2:0] mp;
    logic [2:0][4:0] us;
    xv = '{'{'{130, 131, 125}, '{255, 255, 255}, '{128, 128, 128}},
           '{'{134, 134, 134}, '{130, 130, 130}, '{128, 128, 128}}};
    prv = '{0, 0, 0};
    bp_en = 1'b0;
    mode = DPQ_MODE_444;
    for (int k = 0; k < 2; k++)
    begin
      ql_l = k ? 4'h3 : 4'h1;
      ql_c = k ? 4'h3 : 4'h2;
      forced = (k == 1);
      for (int c = 0; c < 3; c++)
      begin
        ql = (c == 0) ? ql_l : ql_c;
        lim = 1 << (7 - ql);
        mx = 0;
        for (int j = 0; j < 3; j++)
          mx = (sz(qz(xv[k][c][j] - 128, ql)) > mx) ? sz(qz(xv[k][c][j] - 128, ql)) : mx;
        mp[c] = forced || mx >= 8 - ql;
        pr = mp[c] ? 128 + (prv[c] & ((1 << ql) - 1)) : 128;
        us[c] = mp[c] ? 5'(8 - ql) : 5'(mx);
        for (int j = 0; j < 3; j++)
        begin
          q = qz(xv[k][c][j] - pr, ql);
          q = (mp[c] && q >= lim) ? lim - 1 : (mp[c] && q < -lim) ? -lim : q;
          g[j][c] = dpq_smp_t'(xv[k][c][j]);
          ex[j][c] = dpq_smp_t'(rc(pr, q, ql));
        end
        prv[c] = ex[2][c];
      end
      send(g, ex, k == 0, 12'(3 * k), 1'b0, k == 1);
      check(u_mpp, mp);
      check(u_sz, us);
    end
    $display("done prediction and quantizer test");
  endtask : t_pred

  // line of period-four content: block prediction shows as zero residual size
  task automatic t_line(input int hi, input logic en, input dpq_mode_t md, input logic pt, input logic ck12);
    dpq_grp_t g;
    logic bpc;
    pat_lo = 20;
    pat_hi = hi;
    bp_en = en;
    mode = md;
    ql_l = 4'h0;
    ql_c = 4'h0;
    forced = 1'b0;
    for (int h = 0; h <= 15; h += 3)
    begin
      for (int j = 0; j < 3; j++)
        for (int c = 0; c < 3; c++)
          g[j][c] = pv(h + j, pat_lo, pat_hi);
      send(g, g, h == 0, 12'(h), pt && h == 15, 1'b0);
      for (int c = 0; c < 3 && (h == 15 || (h == 12 && ck12)); c++)
      begin
        bpc = h == 15 && en && !pt && hi - 20 > 32 && !(md == DPQ_MODE_420 && c != 0);
        check(u_sz[c], bpc ? 5'h00 : 5'(sz(20 - hi)));
      end
    end
    $display("done block prediction line %0d", hi);
  endtask : t_line

  initial
  begin
    rst_i = 1'b1;
    pix_valid = 1'b0;
    pix = '0;
    slice_s = 1'b0;
    line_s = 1'b0;
    part = 1'b0;
    forced = 1'b0;
    bp_en = 1'b0;
    win_vld = 1'b1;
    ql_l = 4'h0;
    ql_c = 4'h0;
    hp = 12'h000;
    mode = DPQ_MODE_444;
    pat_lo = 0;
    pat_hi = 0;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge sys_clk_i);
    check(pix_rdy, 1'b1);
    check(e_vld, 1'b0);
    check(dpq_link_if_i.valid, 1'b0);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_pred();
    t_line(60, 1'b1, DPQ_MODE_444, 1'b0, 1'b1);
    t_line(52, 1'b1, DPQ_MODE_444, 1'b0, 1'b0);
    t_line(60, 1'b0, DPQ_MODE_444, 1'b0, 1'b0);
    t_line(60, 1'b1, DPQ_MODE_444, 1'b1, 1'b0);
    t_line(60, 1'b1, DPQ_MODE_420, 1'b0, 1'b0);
    t_line(60, 1'b1, DPQ_MODE_422, 1'b0, 1'b0);
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    err_total++;
    $display("BAD %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : dsc_predictor_select_quantizer_tb
`default_nettype wire
